// file: smb_slave_port.sv
/*
  Slave port: bus state machine on the link clock, register port on CLK.
  Assumes a register file outside answers RD_DATA for PTR combinationally
  stable; the bus clock SCL stands still between frames.
*/
`timescale 1ns/100ps
// Summary of operation
// - Answer slave address 0x2E, and 0x0C while ALERT_N is low
// - Host sends address byte 0x5C for write
// - Nine clocks per byte, slave acknowledges
// - Data changes in clock low; rise is stop
// - Host stops after final write byte
// - Host nacks last read byte, then stops
// - Direction fixed by last address byte bit
// - Writes one or two bytes, reads one
// - First write byte loads address pointer
// - Second write byte stores selected register
// - Pointer-only write changes no register
// - Read returns pointed register
// - Pointer holds value between transactions
// - Send, receive, read byte protocols supported
// - Repeated start begins new operation
// - Clock low timeout abandons, can disable
// - Active-low alert output pin
// - Config bit six disables timeout
// - Alert response address returns own address
// - Alert clears only after status read
module smb_slave_port (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SCL_CLK,
  input  wire logic       SDA_IN,
  output logic            SDA_OE,
  output logic [7:0]      PTR,
  input  wire logic [7:0] RD_DATA,
  output logic            WR_STB,
  output logic [7:0]      WR_DATA,
  input  wire logic       ALERT_REQ,
  input  wire logic       STATUS_READ,
  output logic            ALERT_N,
  output logic            TIMEOUT_DISABLE
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_DATA, S_TX, S_SKIP} bus_e;

  // Link-domain state, reset by start/stop or an abandon from CLK domain
  bus_e        st_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic        ack_r;
  logic        tx_r;
  logic [7:0]  txb_r;
  logic        ara_r;
  logic        start_tg_r;
  logic        stop_tg_r;
  logic        wr_tg_r;
  logic        ptr_tg_r;
  logic [7:0]  ptr_nxt;
  logic [7:0]  wdat_r;
  logic        abort_s;
  logic        abort_r;

  // Start and stop are SDA edges with SCL high
  always_ff @(negedge SDA_IN or posedge abort_r)
  begin
    if (abort_r)
      start_tg_r <= 1'b0;
    else if (SCL_CLK)
      start_tg_r <= ~start_tg_r;
  end

  always_ff @(posedge SDA_IN or posedge abort_r)
  begin
    if (abort_r)
      stop_tg_r <= 1'b0;
    else if (SCL_CLK)
      stop_tg_r <= ~stop_tg_r;
  end

  logic start_seen_r;
  logic stop_seen_r;
  logic in_frame;
  assign in_frame = start_tg_r ^ start_seen_r;

  // Sample on rising SCL
  always_ff @(posedge SCL_CLK)
  begin
    if (abort_r)
    begin
      st_r         <= S_IDLE;
      bit_r        <= 4'd0;
      sh_r         <= 8'h00;
      start_seen_r <= start_tg_r;
      stop_seen_r  <= stop_tg_r;
      wr_tg_r      <= 1'b0;
      ptr_tg_r     <= 1'b0;
      ptr_nxt      <= 8'h00;
      wdat_r       <= 8'h00;
      ara_r        <= 1'b0;
    end
    else if (in_frame)
    begin
      // Start or repeated start: new operation
      start_seen_r <= start_tg_r;
      stop_seen_r  <= stop_tg_r;
      st_r         <= S_ADDR;
      bit_r        <= 4'd1;
      sh_r         <= {7'd0, SDA_IN};
      ara_r        <= 1'b0;
    end
    else if (stop_tg_r != stop_seen_r)
    begin
      st_r <= S_IDLE;
    end
    else if (st_r != S_IDLE && st_r != S_SKIP)
    begin
      if (bit_r == 4'd8)
        bit_r <= 4'd0;
      else
        bit_r <= bit_r + 4'd1;
      if (bit_r < 4'd8)
        sh_r <= {sh_r[6:0], SDA_IN};
      if (bit_r == 4'd8)
      begin
        unique case (st_r)
          S_ADDR:
          begin
            // Direction latched here for the whole operation
            if (sh_r[7:1] == smb_pkg::DEV_ADDR)
              st_r <= sh_r[0] ? S_TX : S_PTR;
            else if (sh_r == {smb_pkg::ALERT_RSP_ADDR, 1'b1} && !ALERT_N)
            begin
              ara_r <= 1'b1;
              st_r  <= S_TX;
            end
            else
              st_r <= S_SKIP;
          end
          S_PTR:
          begin
            ptr_nxt  <= sh_r;
            ptr_tg_r <= ~ptr_tg_r;
            // Data register untouched until a second byte
            st_r     <= S_DATA;
          end
          S_DATA:
          begin
            wdat_r  <= sh_r;
            wr_tg_r <= ~wr_tg_r;
            st_r    <= S_SKIP;
          end
          S_TX:
            st_r <= S_SKIP;
          default:
            st_r <= S_SKIP;
        endcase
      end
    end
  end

  // Drive on falling SCL: acks and read bits
  // Async clear so the line is released during reset and after an abandon
  always_ff @(negedge SCL_CLK or posedge abort_r)
  begin
    if (abort_r)
    begin
      ack_r <= 1'b0;
      tx_r  <= 1'b0;
      txb_r <= 8'h00;
    end
    else if (in_frame)
    begin
      ack_r <= 1'b0;
      tx_r  <= 1'b0;
      txb_r <= 8'h00;
    end
    else
    begin
      ack_r <= (bit_r == 4'd8) && (st_r == S_ADDR || st_r == S_PTR || st_r == S_DATA)
               && !(st_r == S_ADDR && !(sh_r[7:1] == smb_pkg::DEV_ADDR
               || (sh_r == {smb_pkg::ALERT_RSP_ADDR, 1'b1} && !ALERT_N)));
      if (st_r == S_TX && bit_r == 4'd0)
        txb_r <= ara_r ? {smb_pkg::DEV_ADDR, 1'b0} : RD_DATA;
      else if (st_r == S_TX)
        txb_r <= {txb_r[6:0], 1'b1};
      tx_r <= (st_r == S_TX) && (bit_r <= 4'd7);
    end
  end
  // Released whenever the byte bit is a one or not addressed
  assign SDA_OE = ack_r | (tx_r & ~txb_r[7]);

  // Crossings into CLK
  logic wr_tg_s;
  logic ptr_tg_s;
  logic scl_s;
  logic wr_tg_d;
  logic ptr_tg_d;
  smb_sync2 u_wr  (.CLK(CLK), .SYS_RST(SYS_RST), .D(wr_tg_r),  .Q(wr_tg_s));
  smb_sync2 u_ptr (.CLK(CLK), .SYS_RST(SYS_RST), .D(ptr_tg_r), .Q(ptr_tg_s));
  smb_sync2 u_scl (.CLK(CLK), .SYS_RST(SYS_RST), .D(SCL_CLK),  .Q(scl_s));

  logic [7:0] cfg1_r;
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wr_tg_d <= 1'b0;
      ptr_tg_d <= 1'b0;
      PTR     <= 8'h00;
      WR_STB  <= 1'b0;
      WR_DATA <= 8'h00;
      cfg1_r  <= 8'h00;
    end
    else
    begin
      wr_tg_d  <= wr_tg_s;
      ptr_tg_d <= ptr_tg_s;
      WR_STB   <= wr_tg_s ^ wr_tg_d;
      if (ptr_tg_s ^ ptr_tg_d)
        PTR <= ptr_nxt;
      if (wr_tg_s ^ wr_tg_d)
      begin
        WR_DATA <= wdat_r;
        if (PTR == 8'(smb_pkg::CFG1_ADDR))
          cfg1_r <= wdat_r;
      end
    end
  end
  assign TIMEOUT_DISABLE = cfg1_r[smb_pkg::TIMEOUT_DISABLE_BIT_BIT];

  // Clock-low timeout; abort cleared once SCL is seen high again
  logic [smb_pkg::CNT_W-1:0] to_cnt_r;
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      to_cnt_r <= '0;
      abort_s  <= 1'b0;
    end
    else if (scl_s || TIMEOUT_DISABLE)
    begin
      to_cnt_r <= '0;
      abort_s  <= 1'b0;
    end
    else if (to_cnt_r == smb_pkg::CNT_W'(smb_pkg::TIMEOUT_CYC))
      abort_s  <= 1'b1;
    else
      to_cnt_r <= to_cnt_r + 1'b1;
  end
  assign abort_r = abort_s | SYS_RST;

  // Alert: set by limit event, cleared after status read with cause gone
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ALERT_N <= 1'b1;
    else if (ALERT_REQ)
      ALERT_N <= 1'b0;
    else if (STATUS_READ)
      ALERT_N <= 1'b1;
  end
endmodule : smb_slave_port

// file: smb_pkg.sv
/*
  Shared constants for the serial management bus slave port and its host end.
  Assumes both ends and the interface compile after this package.
*/
package smb_pkg;
  localparam logic [6:0]  DEV_ADDR       = 7'h2E;
  localparam logic [6:0]  ALERT_RSP_ADDR = 7'h0C;
  localparam int          BYTE_BITS      = 8;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          TIMEOUT_MIN_MS = 15;
  localparam int          TIMEOUT_MAX_MS = 35;
  // Abandon after the least documented time, counted on the system clock
  localparam int          TIMEOUT_CYC    = TIMEOUT_MIN_MS * (CLK_HZ / 1000);
  localparam int          CFG1_ADDR      = 8'h40;
  localparam int          TIMEOUT_DISABLE_BIT_BIT      = 6;
  localparam int          SCL_DIV        = 50;
  localparam int          CNT_W          = 24;
endpackage : smb_pkg

// file: smb_if.sv
/*
  Two-wire bus joining the host end and the slave port.
  Resolves wired-AND levels here from the enables.
*/
`timescale 1ns/100ps
interface smb_if;
  logic scl_o;
  logic scl_oe;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_dev_oe | sda_host_oe);
  modport dev  (input scl, input sda, output sda_dev_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_oe);
endinterface : smb_if

// file: smb_sync2.sv
/*
  Two-flop level synchroniser.
  Assumes the input is a level from another clock domain.
*/
`timescale 1ns/100ps
module smb_sync2 (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic D,
  output logic      Q
);
  logic meta_r;
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      meta_r <= 1'b0;
      Q      <= 1'b0;
    end
    else
    begin
      meta_r <= D;
      Q      <= meta_r;
    end
  end
endmodule : smb_sync2

// file: smb_host_end.sv
/*
  Host end: makes SCL by dividing CLK and runs one operation per request.
  Assumes one request at a time; REQ_BUSY guards it.
*/
`timescale 1ns/100ps
module smb_host_end #(
  parameter int DIV = smb_pkg::SCL_DIV
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REQ_GO,
  input  wire logic       REQ_READ,
  input  wire logic       REQ_TWO,
  input  wire logic [6:0] REQ_ADDR,
  input  wire logic [7:0] REQ_B0,
  input  wire logic [7:0] REQ_B1,
  output logic            REQ_BUSY,
  output logic            REQ_DONE,
  output logic            REQ_NACK,
  output logic [7:0]      RSP_DATA,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  output logic            SDA_OE
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_STOP, H_END} hst_e;
  hst_e       st_r;
  logic [7:0] div_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic       sda_s;
  logic       scl_s;
  logic       tick;
  smb_sync2 u_sda (.CLK(CLK), .SYS_RST(SYS_RST), .D(SDA_IN), .Q(sda_s));
  smb_sync2 u_scl (.CLK(CLK), .SYS_RST(SYS_RST), .D(SCL_IN), .Q(scl_s));
  assign tick   = (div_r == 8'(DIV - 1));
  assign SCL_OE = 1'b1;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST || st_r == H_IDLE)
      div_r <= 8'h00;
    else
      div_r <= tick ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_r <= H_IDLE; ph_r <= 2'd0; bit_r <= 4'd0; byte_r <= 2'd0;
      sh_r <= 8'h00; SCL_OUT <= 1'b1; SDA_OE <= 1'b0;
      REQ_BUSY <= 1'b0; REQ_DONE <= 1'b0; REQ_NACK <= 1'b0; RSP_DATA <= 8'h00;
    end
    else
    begin
      REQ_DONE <= 1'b0;
      unique case (st_r)
        H_IDLE:
          if (REQ_GO)
          begin
            st_r <= H_START; REQ_BUSY <= 1'b1; REQ_NACK <= 1'b0;
            sh_r <= {REQ_ADDR, REQ_READ};
          end
        H_START:
          if (tick)
          begin
            SDA_OE <= 1'b1; st_r <= H_BYTE; ph_r <= 2'd0; bit_r <= 4'd0;
            byte_r <= 2'd0;
          end
        H_BYTE:
          if (tick)
          begin
            ph_r <= ph_r + 2'd1;
            unique case (ph_r)
              2'd0:
              begin
                SCL_OUT <= 1'b0;
              end
              2'd1:
              begin
                // Change data only while clock low
                if (bit_r < 4'd8)
                  SDA_OE <= (byte_r != 2'd0 && REQ_READ) ? 1'b0 : ~sh_r[7];
                else
                  SDA_OE <= 1'b0;
              end
              2'd2:
                SCL_OUT <= 1'b1;
              default:
              begin
                if (bit_r < 4'd8)
                  sh_r <= {sh_r[6:0], sda_s};
                else if (byte_r == 2'd0 && sda_s)
                  REQ_NACK <= 1'b1;
                if (bit_r == 4'd8)
                begin
                  bit_r <= 4'd0;
                  byte_r <= byte_r + 2'd1;
                  if (byte_r != 2'd0 && REQ_READ)
                    RSP_DATA <= sh_r;
                  // Nine clocks per byte, then next byte or stop
                  if ((byte_r == 2'd0 && sda_s) || REQ_READ || byte_r == 2'd2
                      || (byte_r == 2'd1 && !REQ_TWO))
                    st_r <= (byte_r == 2'd0 && REQ_READ && !sda_s) ? H_BYTE : H_STOP;
                  else
                    sh_r <= (byte_r == 2'd0) ? REQ_B0 : REQ_B1;
                  if (byte_r != 2'd0 && REQ_READ)
                    st_r <= H_STOP;
                end
                else
                  bit_r <= bit_r + 4'd1;
              end
            endcase
          end
        H_STOP:
          if (tick)
          begin
            ph_r <= ph_r + 2'd1;
            unique case (ph_r)
              2'd0: SCL_OUT <= 1'b0;
              2'd1: SDA_OE  <= 1'b1;
              2'd2: SCL_OUT <= 1'b1;
              default:
              begin
                SDA_OE <= 1'b0;
                st_r   <= H_END;
              end
            endcase
          end
        default:
        begin
          st_r <= H_IDLE; REQ_BUSY <= 1'b0; REQ_DONE <= 1'b1;
        end
      endcase
    end
  end
endmodule : smb_host_end

// file: smb_monitor.sv
/*
  Checker on the two-wire bus lines.
  Assumes both lines change only just after CLK edges.
*/
`timescale 1ns/100ps
module smb_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] sh_r;
  logic       rd_r;
  logic       rise;
  logic       start;
  logic       stop;
  logic       ack;
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign ack   = rise & (bit_r == 4'h8);
  always_ff @(posedge CLK)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Position in frame; byte count saturates so long frames stay flagged
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || start)
    begin
      bit_r  <= 4'h0;
      byte_r <= 2'h0;
    end
    else if (rise)
    begin
      sh_r  <= {sh_r[6:0], sda};
      bit_r <= ack ? 4'h0 : bit_r + 4'h1;
      if (ack && byte_r != 2'h3)
        byte_r <= byte_r + 2'h1;
      if (ack && byte_r == 2'h0)
        rd_r <= sh_r[0];
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_ack_own;
    ack && byte_r == 2'h0 && sh_r[7:1] == smb_pkg::DEV_ADDR |-> !sda;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");
  property p_ignore;
    ack && byte_r == 2'h0 && sh_r[7:1] != smb_pkg::DEV_ADDR
      && sh_r[7:1] != smb_pkg::ALERT_RSP_ADDR |-> !sda_dev_oe;
  endproperty
  a_ignore: assert property (p_ignore) else $error("foreign address acked");
  property p_frame;
    stop |-> bit_r == 4'h1;
  endproperty
  a_frame: assert property (p_frame) else $error("stop off tenth pulse");
  property p_dev_stable;
    scl && scl_q |-> $stable(sda_dev_oe);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("slave data moved");
  property p_host_stable;
    scl && scl_q && !start && !stop |-> $stable(sda_host_oe);
  endproperty
  a_host_stable: assert property (p_host_stable) else $error("host data moved");
  property p_quiet;
    rise && bit_r != 4'h8 && (byte_r == 2'h0 || !rd_r) |-> !sda_dev_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("slave drove data bit");
  property p_ack_data;
    ack && !rd_r && (byte_r == 2'h1 || byte_r == 2'h2) |-> !sda;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("write byte not acked");
  property p_read_one;
    ack && rd_r && byte_r == 2'h1 |-> !sda_dev_oe [*8];
  endproperty
  a_read_one: assert property (p_read_one) else $error("second read byte");
endmodule : smb_monitor

// file: smbus_register_slave_port_test.sv
/*
  Bench: host end drives the slave port over the bus interface.
  Assumes a register array here answers the slave's register port.
*/
`timescale 1ns/100ps
module smbus_register_slave_port_test;
  logic       CLK;
  logic       SYS_RST;
  logic       go;
  logic       rd;
  logic       two;
  logic [6:0] addr;
  logic [7:0] b0;
  logic [7:0] b1;
  logic       done;
  logic       nack;
  logic [7:0] rsp;
  logic [7:0] ptr;
  logic [7:0] wdat;
  logic       wstb;
  logic       alrt;
  logic       stat;
  logic       alert_n;
  logic       to_dis;
  logic [7:0] regs [256];
  int         fail_count;
  int         n_compared;
  int         n_wr;
  smb_if smb_if_i ();
  smb_host_end #(.DIV(4)) smb_host_end_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .REQ_GO(go), .REQ_READ(rd), .REQ_TWO(two),
    .REQ_ADDR(addr), .REQ_B0(b0), .REQ_B1(b1), .REQ_BUSY(), .REQ_DONE(done),
    .REQ_NACK(nack), .RSP_DATA(rsp), .SCL_IN(smb_if_i.scl), .SDA_IN(smb_if_i.sda),
    .SCL_OUT(smb_if_i.scl_o), .SCL_OE(smb_if_i.scl_oe), .SDA_OE(smb_if_i.sda_host_oe));
  smb_slave_port smb_slave_port_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .SCL_CLK(smb_if_i.scl), .SDA_IN(smb_if_i.sda),
    .SDA_OE(smb_if_i.sda_dev_oe), .PTR(ptr), .RD_DATA(regs[ptr]), .WR_STB(wstb),
    .WR_DATA(wdat), .ALERT_REQ(alrt), .STATUS_READ(stat), .ALERT_N(alert_n),
    .TIMEOUT_DISABLE(to_dis));
  smb_monitor smb_monitor_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .scl(smb_if_i.scl), .sda(smb_if_i.sda),
    .sda_dev_oe(smb_if_i.sda_dev_oe), .sda_host_oe(smb_if_i.sda_host_oe));
  always @(posedge CLK)
    if (wstb === 1'b1)
    begin
      regs[ptr] <= wdat;
      n_wr <= n_wr + 1;
    end
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Whole operation; done follows the stop, so register strobes have landed
  task automatic op(input logic r, input logic t, input logic [6:0] a,
                    input logic [7:0] p, input logic [7:0] d);
    int n;
    n = 0;
    rd = r;
    two = t;
    addr = a;
    b0 = p;
    b1 = d;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    while (done !== 1'b1 && n < 4000)
    begin
      tick(1);
      n++;
    end
    if (n == 4000)
    begin
      fail_count++;
      finish_test();
    end
    tick(2);
  endtask : op
  task automatic t_config;
    check({7'h0, to_dis}, 8'h00);
    op(1'b0, 1'b1, smb_pkg::DEV_ADDR, 8'h40, 8'hBF);
    check({7'h0, to_dis}, 8'h00);
    op(1'b0, 1'b1, smb_pkg::DEV_ADDR, 8'h40, 8'h40);
    check({7'h0, to_dis}, 8'h01);
    op(1'b0, 1'b1, smb_pkg::DEV_ADDR, 8'h40, 8'h00);
    check({7'h0, to_dis}, 8'h00);
    $display("test config done");
  endtask : t_config
  task automatic t_write;
    int n0;
    n0 = n_wr;
    op(1'b0, 1'b1, smb_pkg::DEV_ADDR, 8'h10, 8'h3C);
    check({7'h0, nack}, 8'h00);
    check(ptr, 8'h10);
    check(regs[8'h10], 8'h3C);
    check(8'(n_wr - n0), 8'h01);
    n0 = n_wr;
    op(1'b0, 1'b0, smb_pkg::DEV_ADDR, 8'h21, 8'hFF);
    check(ptr, 8'h21);
    check(8'(n_wr - n0), 8'h00);
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    op(1'b1, 1'b0, smb_pkg::DEV_ADDR, 8'h00, 8'h00);
    check(rsp, 8'h21 ^ 8'hA5);
    op(1'b1, 1'b0, smb_pkg::DEV_ADDR, 8'h00, 8'h00);
    check(rsp, 8'h21 ^ 8'hA5);
    op(1'b0, 1'b0, smb_pkg::DEV_ADDR, 8'h7F, 8'h00);
    op(1'b1, 1'b0, smb_pkg::DEV_ADDR, 8'h00, 8'h00);
    check(rsp, 8'h7F ^ 8'hA5);
    check(ptr, 8'h7F);
    $display("test read done");
  endtask : t_read
  task automatic t_foreign;
    int n0;
    n0 = n_wr;
    op(1'b0, 1'b1, 7'h2F, 8'h55, 8'h66);
    check({7'h0, nack}, 8'h01);
    check(ptr, 8'h7F);
    check(8'(n_wr - n0), 8'h00);
    $display("test foreign address done");
  endtask : t_foreign
  task automatic t_alert;
    check({7'h0, alert_n}, 8'h01);
    alrt = 1'b1;
    tick(1);
    alrt = 1'b0;
    tick(4);
    check({7'h0, alert_n}, 8'h00);
    op(1'b1, 1'b0, smb_pkg::ALERT_RSP_ADDR, 8'h00, 8'h00);
    check({7'h0, nack}, 8'h00);
    check(rsp, {smb_pkg::DEV_ADDR, 1'b0});
    check({7'h0, alert_n}, 8'h00);
    stat = 1'b1;
    tick(1);
    stat = 1'b0;
    tick(4);
    check({7'h0, alert_n}, 8'h01);
    $display("test alert done");
  endtask : t_alert
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    n_wr = 0;
    go = 1'b0;
    rd = 1'b0;
    two = 1'b0;
    addr = 7'h00;
    b0 = 8'h00;
    b1 = 8'h00;
    alrt = 1'b0;
    stat = 1'b0;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'hA5;
    SYS_RST = 1'b1;
    tick(10);
    SYS_RST = 1'b0;
    tick(4);
    t_config();
    t_alert();
    t_write();
    t_read();
    t_foreign();
    finish_test();
  end
endmodule : smbus_register_slave_port_test
